// >>> design/io_fallback_consts.svh
/*
 * Register offsets, field positions and reset values of the I/O fault
 * supervisor.
 * Assumes inclusion by bare name from the supervisor sources.
 */
`ifndef IO_FALLBACK_CONSTS_SVH
`define IO_FALLBACK_CONSTS_SVH

// ****************************************************************
// global register byte addresses
// ****************************************************************
`define IOF_CTRL_ADDR     12'h000
`define IOF_STATUS_ADDR   12'h004
`define IOF_SLOTST_ADDR   12'h008
// slot windows: address bits [11:6] select, [5:4] slot, [3:2] reg
`define IOF_SLOT_SEL      6'h01
`define IOF_S_OUTIMG      2'h0
`define IOF_S_FBCFG       2'h1
`define IOF_S_FORCE       2'h2
`define IOF_S_INPUT       2'h3

// ****************************************************************
// control register bit positions
// ****************************************************************
`define IOF_C_CONFIGURED  0
`define IOF_C_APPRUN      1
`define IOF_C_TASKRUN     2
`define IOF_C_FBSYSBIT    3
`define IOF_C_DEBUGFB     4
`define IOF_C_BREAK       5
`define IOF_C_BLOCKING    6
`define IOF_CTRL_W        7
`define IOF_CTRL_RST      7'h00

// ****************************************************************
// status register bit positions
// ****************************************************************
`define IOF_ST_SYSBIT     0
`define IOF_ST_LAMP       1
`define IOF_ST_EVERRUN    2
`define IOF_ST_TASKEVER   3
`define IOF_ST_RELAY0     4

// slot status: fault bits low, two state bits per slot from here
`define IOF_SS_STATE_LSB  8
// upper field of a slot register starts here
`define IOF_HI_LSB        8
`define IOF_REF_LSB       16

`endif

// >>> design/io_fallback_pkg.sv
/*
 * Types shared by the I/O fault supervisor.
 * Assumes nothing of its surroundings.
 */
package io_fallback_pkg;

    // presence and match state of one module slot
    typedef enum logic [1:0] {
        SLOT_EMPTY = 2'b00,
        SLOT_OK    = 2'b01,
        SLOT_BAD   = 2'b10
    } slotState_t;

endpackage

// >>> design/io_fallback_fault_supervisor.sv
/*
 * I/O fault supervisor: live module removal and reinsertion, input
 * image handling, output safety value, fallback and maintain state,
 * fault indication and alarm relays, with an APB register slave.
 * Assumes module-side pins are asynchronous to ref_clk and quasi-static
 * (type codes settle before presence is seen); APB on ref_clk.
 */
// Chosen here: the register addresses and the APB register port.
// Operation
// - removal raises I/O sysbits and module/channel faults
// - absent discrete inputs read 0 unless forced
// - I/O lamp on once removal detected
// - insertion retried with previous slot configuration
// - same type: channels reused, faults cleared
// - other type: channels ignored, faults kept
// - safety value 0 in listed situations
// - listed stop conditions enter output fallback
// - fallback channel drives configured value, image kept
// - maintain channel holds last driven value
// - fallback selection per channel
// - default fallback behaviour forces zero
// - faulty discrete input reads 0 unless forced
// - other faulty inputs keep last value
// - output computed, sent only to matching module
// - any I/O fault sets sysbits and lamp
// - base relay open while application stopped
// - other relays follow their rack supply
`timescale 1ns/1ps
`include "io_fallback_consts.svh"

module io_fallback_fault_supervisor
    import io_fallback_pkg::*;
#(
    parameter int NSLOT = 4,
    parameter int NCH   = 8,
    parameter int REFW  = 8,
    parameter int NRACK = 2
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // module slots, asynchronous
    input  wire logic [NSLOT-1:0]      modPresent,
    input  wire logic [NSLOT*REFW-1:0] modTypeRef,
    input  wire logic [NSLOT-1:0]      modDiscIn,
    input  wire logic [NSLOT-1:0]      modFault,
    input  wire logic [NSLOT*NCH-1:0]  modChanFault,
    input  wire logic [NSLOT*NCH-1:0]  modInData,
    input  wire logic [NSLOT-1:0]      modCommLoss,
    input  wire logic [NSLOT-1:0]      procCommFault,
    input  wire logic [NSLOT-1:0]      slotPowerOk,
    input  wire logic [NRACK-1:0]      rackSupplyOk,
    // outputs to modules and front panel
    output logic      [NSLOT*NCH-1:0]  modOutData,
    output logic      [NRACK-1:0]      relayClosed,
    output logic                       ioSysBit,
    output logic                       ioLamp
);

    // six single-bit pins per slot, plus type and two channel buses
    localparam int SW = NSLOT*(6+REFW+2*NCH) + NRACK;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [SW-1:0] syncA_r;
    logic [SW-1:0] syncB_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= {modPresent, modTypeRef, modDiscIn, modFault,
                        modChanFault, modInData, modCommLoss,
                        procCommFault, slotPowerOk, rackSupplyOk};
            syncB_r <= syncA_r;
        end
    end

    logic [NSLOT-1:0]      presS;
    logic [NSLOT*REFW-1:0] refS;
    logic [NSLOT-1:0]      discS;
    logic [NSLOT-1:0]      mfS;
    logic [NSLOT*NCH-1:0]  cfS;
    logic [NSLOT*NCH-1:0]  inS;
    logic [NSLOT-1:0]      clS;
    logic [NSLOT-1:0]      pcfS;
    logic [NSLOT-1:0]      spS;
    logic [NRACK-1:0]      rackS;

    assign {presS, refS, discS, mfS, cfS, inS, clS, pcfS, spS, rackS}
        = syncB_r;

    // ****************************************************************
    // apb decode and control register
    // ****************************************************************
    logic                 wrEn;
    logic                 slotHit;
    logic [1:0]           slotIdx;
    logic [1:0]           slotReg;
    logic                 mapped;
    logic [`IOF_CTRL_W-1:0] ctrl_r;
    logic [31:0]          prdata_r;
    logic [31:0]          rdMux;

    assign pready  = 1'b1;
    assign wrEn    = psel & penable & pwrite;
    assign slotHit = (paddr[11:6] == `IOF_SLOT_SEL);
    assign slotIdx = paddr[5:4];
    assign slotReg = paddr[3:2];
    assign mapped  = slotHit || paddr == `IOF_CTRL_ADDR ||
                     paddr == `IOF_STATUS_ADDR ||
                     paddr == `IOF_SLOTST_ADDR;
    // unmapped access answers with an error, zero wait states
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `IOF_CTRL_RST;
        end else if (wrEn && paddr == `IOF_CTRL_ADDR) begin
            ctrl_r <= pwdata[`IOF_CTRL_W-1:0];
        end
    end

    logic configured;
    logic appRun;
    logic taskRun;
    logic blocking;
    logic stopCause;

    assign configured = ctrl_r[`IOF_C_CONFIGURED];
    assign appRun     = ctrl_r[`IOF_C_APPRUN];
    assign taskRun    = ctrl_r[`IOF_C_TASKRUN];
    assign blocking   = ctrl_r[`IOF_C_BLOCKING];
    assign stopCause  = ~appRun | blocking | ~taskRun |
                        ctrl_r[`IOF_C_BREAK] | ctrl_r[`IOF_C_FBSYSBIT] |
                        ctrl_r[`IOF_C_DEBUGFB];

    // ****************************************************************
    // run history
    // ****************************************************************
    logic everRun_r;
    logic taskEver_r;

    // history forgotten when configuration is withdrawn
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            everRun_r  <= 1'b0;
            taskEver_r <= 1'b0;
        end else if (!configured) begin
            everRun_r  <= 1'b0;
            taskEver_r <= 1'b0;
        end else begin
            everRun_r  <= everRun_r | appRun;
            taskEver_r <= taskEver_r | (appRun & taskRun);
        end
    end

    // ****************************************************************
    // per-slot state, registers and channels
    // ****************************************************************
    slotState_t                  slotState_r [NSLOT];
    logic [NSLOT-1:0]            slotFault;
    logic [NSLOT-1:0]            safeS;
    logic [NSLOT-1:0]            fbS;
    logic [NSLOT-1:0][NCH-1:0]   outImg_r;
    logic [NSLOT-1:0][NCH-1:0]   fbVal_r;
    logic [NSLOT-1:0][NCH-1:0]   fbMaint_r;
    logic [NSLOT-1:0][NCH-1:0]   forceVal_r;
    logic [NSLOT-1:0][NCH-1:0]   forceEn_r;
    logic [NSLOT-1:0][NCH-1:0]   inImg_r;
    logic [NSLOT-1:0][NCH-1:0]   out_r;
    logic [NSLOT-1:0][REFW-1:0]  refStore_r;
    logic [NSLOT-1:0]            refValid_r;

    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
        logic [REFW-1:0] refNow;
        logic            wrSlot;
        slotState_t      stNxt;

        assign refNow = refS[s*REFW +: REFW];
        assign wrSlot = wrEn && slotHit && slotIdx == 2'(s);

        // fallback to zero out of reset
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                outImg_r[s]   <= '0;
                fbVal_r[s]    <= '0;
                fbMaint_r[s]  <= '0;
                forceVal_r[s] <= '0;
                forceEn_r[s]  <= '0;
            end else if (wrSlot) begin
                unique case (slotReg)
                    `IOF_S_OUTIMG: begin
                        outImg_r[s] <= pwdata[NCH-1:0];
                    end
                    `IOF_S_FBCFG: begin
                        fbVal_r[s]   <= pwdata[NCH-1:0];
                        fbMaint_r[s] <= pwdata[`IOF_HI_LSB +: NCH];
                    end
                    `IOF_S_FORCE: begin
                        forceVal_r[s] <= pwdata[NCH-1:0];
                        forceEn_r[s]  <= pwdata[`IOF_HI_LSB +: NCH];
                    end
                    `IOF_S_INPUT: begin
                    end
                endcase
            end
        end

        // reinsertion checked against the stored type
        always_comb begin
            stNxt = slotState_r[s];
            unique case (slotState_r[s])
                SLOT_EMPTY: begin
                    if (presS[s]) begin
                        stNxt = (!refValid_r[s] ||
                                 refNow == refStore_r[s])
                                ? SLOT_OK : SLOT_BAD;
                    end
                end
                SLOT_OK, SLOT_BAD: begin
                    // removal drops the slot to empty
                    if (!presS[s]) begin
                        stNxt = SLOT_EMPTY;
                    end
                end
                default: stNxt = SLOT_EMPTY;
            endcase
        end

        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                slotState_r[s] <= SLOT_EMPTY;
                refStore_r[s]  <= '0;
                refValid_r[s]  <= 1'b0;
            end else begin
                slotState_r[s] <= stNxt;
                // first module seen defines the slot configuration
                if (presS[s] && !refValid_r[s]) begin
                    refStore_r[s] <= refNow;
                    refValid_r[s] <= 1'b1;
                end
            end
        end

        assign slotFault[s] = slotState_r[s] != SLOT_OK | mfS[s] |
                              pcfS[s] | (|cfS[s*NCH +: NCH]);
        assign safeS[s] = ~configured | ~everRun_r | ~taskEver_r |
                          ~spS[s] | slotState_r[s] != SLOT_OK;
        assign fbS[s] = stopCause | clS[s];

        for (genvar c = 0; c < NCH; c++) begin : g_ch
            logic chFault;
            logic inNxt;
            logic outNxt;

            assign chFault = cfS[s*NCH + c] | pcfS[s] |
                             slotState_r[s] != SLOT_OK;

            always_comb begin
                inNxt = inS[s*NCH + c];
                if (forceEn_r[s][c]) begin
                    inNxt = forceVal_r[s][c];
                end else if (chFault) begin
                    inNxt = discS[s] ? 1'b0 : inImg_r[s][c];
                end
            end

            // per channel mode; gated by safe
            always_comb begin
                if (safeS[s]) begin
                    outNxt = 1'b0;
                end else if (fbS[s]) begin
                    outNxt = fbMaint_r[s][c] ? out_r[s][c]
                                             : fbVal_r[s][c];
                end else begin
                    outNxt = outImg_r[s][c];
                end
            end

            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    inImg_r[s][c] <= 1'b0;
                    out_r[s][c]   <= 1'b0;
                end else begin
                    inImg_r[s][c] <= inNxt;
                    out_r[s][c]   <= outNxt;
                end
            end
        end
    end

    assign modOutData = out_r;

    // ****************************************************************
    // fault indication and alarm relays
    // ****************************************************************
    logic             ioSysBit_r;
    logic             ioLamp_r;
    logic [NRACK-1:0] relay_r;

    // lamp and sysbits follow any slot fault
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ioSysBit_r <= 1'b0;
            ioLamp_r   <= 1'b0;
        end else begin
            ioSysBit_r <= |slotFault;
            ioLamp_r   <= |slotFault;
        end
    end

    // base rack open unless app and task run without break or blocking; others follow supply
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            relay_r <= '0;
        end else begin
            relay_r    <= rackS;
            relay_r[0] <= appRun & taskRun & ~blocking &
                          ~ctrl_r[`IOF_C_BREAK];
        end
    end

    assign ioSysBit    = ioSysBit_r;
    assign ioLamp      = ioLamp_r;
    assign relayClosed = relay_r;

    // ****************************************************************
    // read data, sampled in the setup cycle
    // ****************************************************************
    always_comb begin
        rdMux = '0;
        if (paddr == `IOF_CTRL_ADDR) begin
            rdMux[`IOF_CTRL_W-1:0] = ctrl_r;
        end else if (paddr == `IOF_STATUS_ADDR) begin
            rdMux[`IOF_ST_SYSBIT]   = ioSysBit_r;
            rdMux[`IOF_ST_LAMP]     = ioLamp_r;
            rdMux[`IOF_ST_EVERRUN]  = everRun_r;
            rdMux[`IOF_ST_TASKEVER] = taskEver_r;
            rdMux[`IOF_ST_RELAY0]   = relay_r[0];
        end else if (paddr == `IOF_SLOTST_ADDR) begin
            rdMux[NSLOT-1:0] = slotFault;
            for (int i = 0; i < NSLOT; i++) begin
                rdMux[`IOF_SS_STATE_LSB + 2*i +: 2] = slotState_r[i];
            end
        end else if (slotHit) begin
            unique case (slotReg)
                `IOF_S_OUTIMG: rdMux[NCH-1:0] = outImg_r[slotIdx];
                `IOF_S_FBCFG: begin
                    rdMux[NCH-1:0] = fbVal_r[slotIdx];
                    rdMux[`IOF_HI_LSB +: NCH] = fbMaint_r[slotIdx];
                end
                `IOF_S_FORCE: begin
                    rdMux[NCH-1:0] = forceVal_r[slotIdx];
                    rdMux[`IOF_HI_LSB +: NCH] = forceEn_r[slotIdx];
                end
                `IOF_S_INPUT: begin
                    rdMux[NCH-1:0] = inImg_r[slotIdx];
                    rdMux[`IOF_HI_LSB +: NCH] =
                        cfS[slotIdx*NCH +: NCH];
                    rdMux[`IOF_REF_LSB +: REFW] = refStore_r[slotIdx];
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_r <= '0;
        end else if (psel && !penable) begin
            prdata_r <= rdMux;
        end
    end

    // ****************************************************************
    // assertions, slot 0 channel 0 as representative
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_removeSys;
        !presS[0] |-> ##2 ioSysBit_r;
    endproperty
    a_removeSys: assert property (p_removeSys)
        else $error("removal did not raise sysbit");

    property p_removeLamp;
        !presS[0] |-> ##2 ioLamp;
    endproperty
    a_removeLamp: assert property (p_removeLamp)
        else $error("removal did not light lamp");

    property p_absentZero;
        slotState_r[0] == SLOT_EMPTY && discS[0] && !forceEn_r[0][0]
            |=> !inImg_r[0][0];
    endproperty
    a_absentZero: assert property (p_absentZero)
        else $error("absent discrete input not zero");

    property p_mismatch;
        slotState_r[0] == SLOT_EMPTY && presS[0] && refValid_r[0] &&
            refS[REFW-1:0] != refStore_r[0] |=> slotState_r[0] == SLOT_BAD;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("mismatched module accepted");

    property p_safe;
        safeS[0] |=> modOutData[NCH-1:0] == '0;
    endproperty
    a_safe: assert property (p_safe)
        else $error("safety value not applied");

    property p_fbValue;
        !safeS[0] && fbS[0] && !fbMaint_r[0][0]
            |=> out_r[0][0] == $past(fbVal_r[0][0]);
    endproperty
    a_fbValue: assert property (p_fbValue)
        else $error("fallback value not driven");

    property p_maintain;
        !safeS[0] && fbS[0] && fbMaint_r[0][0]
            |=> $stable(out_r[0][0]);
    endproperty
    a_maintain: assert property (p_maintain)
        else $error("maintained output changed");

    property p_resume;
        !safeS[0] && !fbS[0] |=> out_r[0] == $past(outImg_r[0]);
    endproperty
    a_resume: assert property (p_resume)
        else $error("output not from image in run");

    property p_baseRelay;
        !appRun ##1 !appRun |-> !relayClosed[0];
    endproperty
    a_baseRelay: assert property (p_baseRelay)
        else $error("base relay closed while stopped");

    property p_rackRelay;
        rackS[NRACK-1] |=> relayClosed[NRACK-1];
    endproperty
    a_rackRelay: assert property (p_rackRelay)
        else $error("rack relay ignores supply");

endmodule

// >>> bench/io_module_model.sv
/*
 * Plug-in module model for the I/O fault supervisor bench.
 * Assumes the bench commands plugging, type and input values per slot.
 */
`timescale 1ns/1ps
module io_module_model #(
    parameter int NSLOT = 4,
    parameter int NCH   = 8,
    parameter int REFW  = 8
) (
    // commands from the bench
    input  wire logic                  ref_clk,
    input  wire logic [NSLOT-1:0]      plugged,
    input  wire logic [NSLOT*REFW-1:0] typeSet,
    input  wire logic [NSLOT*NCH-1:0]  dataSet,
    // pins towards the supervisor
    output logic      [NSLOT-1:0]      modPresent,
    output logic      [NSLOT*REFW-1:0] modTypeRef,
    output logic      [NSLOT*NCH-1:0]  modInData
);
    // empty slot data lines float: show a changing pattern, never old data; type lines read inverted
    logic [NCH-1:0] noise_r = '0;
    always @(posedge ref_clk) noise_r <= ~noise_r;
    always_comb begin
        modPresent = plugged;
        for (int s = 0; s < NSLOT; s++) begin
            modTypeRef[s*REFW +: REFW] = plugged[s] ?
                typeSet[s*REFW +: REFW] : ~typeSet[s*REFW +: REFW];
            modInData[s*NCH +: NCH] = plugged[s] ?
                dataSet[s*NCH +: NCH] : noise_r ^ NCH'(s);
        end
    end
endmodule

// >>> bench/io_fallback_fault_supervisor_tb_top.sv
/*
 * Self-checking bench of the I/O fault supervisor.
 * Assumes zero-wait APB slave and two-cycle pin synchronisers.
 */
`timescale 1ns/1ps
module io_fallback_fault_supervisor_tb_top;
    // ****************************************************************
    // stimulus signals
    // ****************************************************************
    logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, ioSysBit, ioLamp;
    logic [3:0] plugged = 4'hf, modDiscIn = 4'h1, modFault = '0;
    logic [3:0] modCommLoss = '0, procCommFault = '0, slotPowerOk = 4'hf;
    logic [31:0] typeSet = 32'h44332211, dataSet = '0;
    logic [31:0] modChanFault = '0, modOutData, modInData, modTypeRef;
    logic [3:0] modPresent;
    logic [1:0] rackSupplyOk = 2'b11, relayClosed;
    int fails = 0, total_checks = 0, cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    io_module_model mdl (.ref_clk(ref_clk), .plugged(plugged),
        .typeSet(typeSet), .dataSet(dataSet), .modPresent(modPresent),
        .modTypeRef(modTypeRef), .modInData(modInData));
    io_fallback_fault_supervisor dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .modPresent(modPresent),
        .modTypeRef(modTypeRef), .modDiscIn(modDiscIn),
        .modFault(modFault), .modChanFault(modChanFault),
        .modInData(modInData), .modCommLoss(modCommLoss),
        .procCommFault(procCommFault), .slotPowerOk(slotPowerOk),
        .rackSupplyOk(rackSupplyOk), .modOutData(modOutData),
        .relayClosed(relayClosed), .ioSysBit(ioSysBit), .ioLamp(ioLamp));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        // only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic outs(input logic [31:0] e);
        w(6);
        chk({24'h0, modOutData[7:0]}, e);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        w(4);
        chk({30'h0, relayClosed}, 32'h2);
        chk(modOutData, 32'h0);
        apb(0, 12'h008, 0);
        chk(rd, 32'h5500);
        apb(0, 12'h0fc, 0);
        chk({err, rd[30:0]}, 32'h80000000);
    endtask
    task automatic t_run();
        apb(1, 12'h040, 32'ha5);
        apb(1, 12'h050, 32'h1);
        apb(1, 12'h000, 32'h1);
        outs(0);
        apb(1, 12'h000, 32'h3);
        outs(0);
        apb(1, 12'h000, 32'h7);
        outs(32'ha5);
        chk({30'h0, relayClosed}, 32'h3);
    endtask
    task automatic t_fb();
        logic [6:0] c [7] = '{7'hf, 7'h17, 7'h27, 7'h47, 7'h3, 7'h5, 7'h7};
        apb(1, 12'h044, 32'hf00f);
        foreach (c[i]) begin
            apb(1, 12'h000, {25'h0, c[i]});
            if (i == 6) modCommLoss[0] <= 1;
            outs(32'haf);
            // slot 1 runs on its image once only slot 0 lost comms
            chk(modOutData[8], i == 6);
            chk(relayClosed[0], c[i] == 7'hf || c[i] == 7'h17 ||
                                c[i] == 7'h7);
        end
        apb(0, 12'h040, 0);
        chk(rd, 32'ha5);
        modCommLoss[0] <= 0;
        outs(32'ha5);
    endtask
    task automatic t_remove();
        plugged[0] <= 0;
        w(6);
        chk({ioSysBit, ioLamp}, 32'h3);
        apb(0, 12'h008, 0);
        chk(rd, 32'h5401);
        apb(0, 12'h04c, 0);
        chk(rd[7:0], 0);
        apb(1, 12'h048, 32'h0101);
        w(3);
        apb(0, 12'h04c, 0);
        chk(rd[7:0], 32'h1);
        apb(1, 12'h048, 0);
        typeSet[7:0] <= 8'h99;
        w(2);
        plugged[0] <= 1;
        outs(0);
        apb(0, 12'h008, 0);
        chk(rd, 32'h5601);
        chk(ioLamp, 1);
        plugged[0] <= 0;
        w(4);
        typeSet[7:0] <= 8'h11;
        w(2);
        plugged[0] <= 1;
        outs(32'ha5);
        apb(0, 12'h008, 0);
        chk(rd, 32'h5500);
        chk({ioSysBit, ioLamp}, 0);
    endtask
    task automatic t_inputs();
        dataSet <= 32'h3cff;
        w(6);
        apb(0, 12'h05c, 0);
        chk(rd[7:0], 32'h3c);
        modChanFault <= 32'hff0f;
        dataSet <= 32'hc3ff;
        w(6);
        apb(0, 12'h05c, 0);
        chk(rd[15:0], 32'hff3c);
        apb(0, 12'h04c, 0);
        chk(rd[7:0], 32'hf0);
        chk(ioLamp, 1);
        modChanFault <= 0;
        slotPowerOk[0] <= 0;
        outs(0);
        slotPowerOk[0] <= 1;
        procCommFault[2] <= 1;
        modFault[3] <= 1;
        rackSupplyOk[1] <= 0;
        w(6);
        chk({ioSysBit, ioLamp}, 32'h3);
        chk({30'h0, relayClosed}, 32'h1);
    endtask
    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        w(8);
        reset_n <= 1;
        t_reset();
        t_run();
        t_fb();
        t_remove();
        t_inputs();
        close_out();
    end
endmodule
